// >>> rtl/hibernate_rtc_power_controller.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "hib_defs.svh"

// What this block does
// (RULE_01) Low-battery detection runs only while its enable bit is set.
// (RULE_02) Detected low battery sets the low-battery raw status flag.
// (RULE_03) Abort bit plus low battery refuses hibernation; power stays on.
// (RULE_04) No low-battery sampling or flag update while hibernating.
// (RULE_05) 32-bit seconds counter steps once per predivider second.
// (RULE_06) Predivider counts reference ticks down, strobes each second.
// (RULE_07) Trim value reloads one second in 64; others use nominal.
// (RULE_08) Trim above nominal slows the counter, below speeds it.
// (RULE_09) Two 32-bit match registers; equality raises a match event.
// (RULE_10) Counter and predivider advance only with counter enable set.
// (RULE_11) Load write replaces the counter at once, running or not.
// (RULE_12) Counting continues through hibernation while backup is valid.
// (RULE_13) 64 retained 32-bit words kept through hibernation.
// (RULE_14) Hibernation asserts regulator-off; wake releases it.
// (RULE_15) Setting the sleep request bit starts hibernation.
// (RULE_16) Software enables a wake source before requesting sleep.
// (RULE_17) Pin wake and match wake each need their own enable.
// (RULE_18) After wake the CPU gets POR; raw status keeps the cause.
// (RULE_19) Events recorded: wake pin, RTC match, low battery.
// (RULE_20) Interrupt is OR of all enabled pending events.
// (RULE_21) Raw view shows all pending; masked view only unmasked ones.
// (RULE_22) Mask bit enables an event; writing one to clear clears it.
// (RULE_23) Write-complete flag clears on slow write, sets when finished.
// (RULE_24) Crystal source divided by 128 to form the reference.
// (RULE_25) Wake pin synchronised before its assertion is detected.
module hibernate_rtc_power_controller #(
  parameter int MEM_DEPTH = 64,
  parameter int MEM_AW = 6
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REF_CLK_IN,
  input wire logic WAKE_N,
  input wire logic LOW_BATT_IN,
  input wire logic VBAT_OK,
  output logic REGULATOR_OFF_N_OUT,
  output logic REGULATOR_OFF_N_OE,
  output logic IRQ
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] filt_reg;
  logic [NSYNC-1:0] filt_next;

  assign pin_in = {VBAT_OK, LOW_BATT_IN, WAKE_N, REF_CLK_IN};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // Level moves only once the second and third stages agree
      assign filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] :
                             filt_reg[gi];
    end
  endgenerate

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      // Idle levels, so no false wake edge follows reset
      s1_reg <= `RST_PIN_LEVELS;
      s2_reg <= `RST_PIN_LEVELS;
      s3_reg <= `RST_PIN_LEVELS;
      filt_reg <= `RST_PIN_LEVELS;
    end else if (CE) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  logic ref_level;
  logic ref_prev_reg;
  logic ref_edge;
  logic wake_n_level;
  logic wake_n_prev_reg;
  logic wake_assert;
  logic low_batt_level;
  logic vbat_ok_level;

  assign ref_level = filt_reg[0];
  assign wake_n_level = filt_reg[1];
  assign low_batt_level = filt_reg[2];
  assign vbat_ok_level = filt_reg[3];
  assign ref_edge = ref_level & ~ref_prev_reg;
  assign wake_assert = ~wake_n_level & wake_n_prev_reg; // [RULE_25]

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [`CTL_WIDTH-1:0] ctrl_reg;
  logic [`CTL_WIDTH-1:0] ctrl_next;
  logic wc_reg;
  logic wc_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] match_a_reg;
  logic [31:0] match_b_reg;
  logic [31:0] load_reg;
  logic [15:0] trim_reg;
  logic [`EV_WIDTH-1:0] mask_reg;
  logic [`EV_WIDTH-1:0] raw_reg;
  logic [`EV_WIDTH-1:0] raw_next;
  logic [15:0] prediv_reg;
  logic [15:0] prediv_next;
  logic [5:0] sec_index_reg;
  logic [6:0] xtal_div_reg;
  logic [31:0] prdata_reg;
  logic eq_a_prev_reg;
  logic eq_b_prev_reg;
  hib_pkg::power_state_e state_reg;
  hib_pkg::power_state_e state_next;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic setup_phase;
  logic wr_access;
  logic hit_counter;
  logic hit_match_a;
  logic hit_match_b;
  logic hit_load;
  logic hit_control;
  logic hit_mask;
  logic hit_raw;
  logic hit_masked;
  logic hit_clear;
  logic hit_trim;
  logic hit_data;
  logic hit_any;
  logic slow_write;
  logic [9:0] word_index;
  logic [9:0] data_index;
  logic [MEM_AW-1:0] mem_addr;
  logic [31:0] mem_rdata;
  logic data_sel_reg;

  assign setup_phase = PSEL & ~PENABLE;
  assign wr_access = PSEL & PENABLE & PWRITE;
  assign hit_counter = PADDR == `OFF_COUNTER;
  assign hit_match_a = PADDR == `OFF_MATCH_A;
  assign hit_match_b = PADDR == `OFF_MATCH_B;
  assign hit_load = PADDR == `OFF_LOAD;
  assign hit_control = PADDR == `OFF_CONTROL;
  assign hit_mask = PADDR == `OFF_MASK;
  assign hit_raw = PADDR == `OFF_RAW;
  assign hit_masked = PADDR == `OFF_MASKED;
  assign hit_clear = PADDR == `OFF_CLEAR;
  assign hit_trim = PADDR == `OFF_TRIM;
  assign hit_data = (PADDR[1:0] == 2'h0) && (PADDR >= `OFF_DATA_FIRST) &&
                    (PADDR <= `OFF_DATA_LAST);
  assign hit_any = hit_counter | hit_match_a | hit_match_b | hit_load |
                   hit_control | hit_mask | hit_raw | hit_masked |
                   hit_clear | hit_trim | hit_data;
  assign slow_write = wr_access & (hit_match_a | hit_match_b | hit_load |
                                   hit_trim | hit_data);
  assign word_index = PADDR[11:2];
  assign data_index = word_index - `DATA_FIRST_WORD;
  assign mem_addr = data_index[MEM_AW-1:0];

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;
  assign PRDATA = data_sel_reg ? mem_rdata : prdata_reg;

  // ==========================================================================
  // Retained memory
  // ==========================================================================
  retained_memory #(
    .WIDTH(32),
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .clk(CLK_SYS),
    .ce(CE),
    .wr_en(wr_access & hit_data), // [RULE_13]
    .addr(mem_addr),
    .wr_data(PWDATA),
    .rd_data(mem_rdata)
  );

  // ==========================================================================
  // Reference tick and predivider
  // ==========================================================================
  logic ref_clock_on;
  logic xtal_source;
  logic ref_tick;
  logic running;
  logic sec_strobe;
  logic [15:0] reload_value;

  assign ref_clock_on = ctrl_reg[`CTL_REF_CLOCK_ENABLE];
  assign xtal_source = ~ctrl_reg[`CTL_REF_SOURCE_SELECT];
  assign ref_tick = ref_clock_on & ref_edge &
                    (~xtal_source | (xtal_div_reg == `XTAL_DIV_LAST)); // [RULE_24]
  assign running = ctrl_reg[`CTL_COUNTER_ENABLE] & vbat_ok_level; // [RULE_10] [RULE_12]
  assign sec_strobe = running & ref_tick & (prediv_reg == 16'h0000); // [RULE_06]
  assign reload_value = (sec_index_reg == `TRIM_SECOND_INDEX) ? trim_reg :
                        `PREDIV_NOMINAL; // [RULE_07] [RULE_08]
  assign prediv_next = sec_strobe ? reload_value :
                       (running & ref_tick) ? prediv_reg - 16'h0001 :
                       prediv_reg;

  // Load write wins over the second strobe
  assign count_next = (wr_access & hit_load) ? PWDATA :
                      sec_strobe ? count_reg + 32'h00000001 :
                      count_reg; // [RULE_05] [RULE_11]

  // ==========================================================================
  // Events
  // ==========================================================================
  logic eq_a;
  logic eq_b;
  logic low_batt_sample;
  logic [`EV_WIDTH-1:0] ev_set;
  logic [`EV_WIDTH-1:0] ev_clear;
  logic [`EV_WIDTH-1:0] masked_status;

  assign eq_a = count_reg == match_a_reg;
  assign eq_b = count_reg == match_b_reg;
  assign low_batt_sample = ctrl_reg[`CTL_LOW_BATT_DETECT_ENABLE] &
                           (state_reg == hib_pkg::AWAKE) &
                           low_batt_level; // [RULE_01] [RULE_04]
  assign ev_set[`EV_MATCH_A] = eq_a & ~eq_a_prev_reg; // [RULE_09]
  assign ev_set[`EV_MATCH_B] = eq_b & ~eq_b_prev_reg;
  assign ev_set[`EV_LOW_BATT] = low_batt_sample; // [RULE_02]
  assign ev_set[`EV_WAKE_PIN] = wake_assert; // [RULE_19]
  assign ev_clear = (wr_access & hit_clear) ? PWDATA[`EV_WIDTH-1:0] :
                    {`EV_WIDTH{1'b0}}; // [RULE_22]
  // A new event beats a clear in the same cycle
  assign raw_next = (raw_reg & ~ev_clear) | ev_set;
  assign masked_status = raw_reg & mask_reg; // [RULE_21]
  assign IRQ = |masked_status; // [RULE_20]

  // ==========================================================================
  // Power state
  // ==========================================================================
  logic sleep_req;
  logic abort_sleep;
  logic wake_event;

  assign sleep_req = ctrl_reg[`CTL_SLEEP_REQUEST]; // [RULE_15]
  assign abort_sleep = ctrl_reg[`CTL_LOW_BATT_ABORT] &
                       (raw_reg[`EV_LOW_BATT] | low_batt_sample); // [RULE_03]
  assign wake_event = (ctrl_reg[`CTL_PIN_WAKE_ENABLE] & wake_assert) |
                      (ctrl_reg[`CTL_MATCH_WAKE_ENABLE] &
                       (ev_set[`EV_MATCH_A] | ev_set[`EV_MATCH_B])); // [RULE_17]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hib_pkg::AWAKE: begin
        if (sleep_req && !abort_sleep) begin
          state_next = hib_pkg::HIBERNATE;
        end
      end
      hib_pkg::HIBERNATE: begin
        if (wake_event) begin
          state_next = hib_pkg::AWAKE;
        end
      end
      default: begin
        state_next = hib_pkg::AWAKE;
      end
    endcase
  end

  // Open-drain, active low: pulled low while hibernating
  assign REGULATOR_OFF_N_OUT = 1'b0;
  assign REGULATOR_OFF_N_OE = state_reg == hib_pkg::HIBERNATE; // [RULE_14]

  // ==========================================================================
  // Control register and write-complete flag
  // ==========================================================================
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_access && hit_control) begin
      ctrl_next = PWDATA[`CTL_WIDTH-1:0];
    end else if (state_reg == hib_pkg::AWAKE && sleep_req && abort_sleep) begin
      ctrl_next[`CTL_SLEEP_REQUEST] = 1'b0; // [RULE_03]
    end else if (state_reg == hib_pkg::HIBERNATE && wake_event) begin
      // Leaves the wake cause in raw status for the restarted CPU
      ctrl_next[`CTL_SLEEP_REQUEST] = 1'b0; // [RULE_18]
    end
  end

  // Set on the next reference edge after a slow-domain write; set wins
  assign wc_next = ref_edge ? 1'b1 : slow_write ? 1'b0 : wc_reg; // [RULE_23]

  // ==========================================================================
  // Read data, captured in the setup phase
  // ==========================================================================
  logic [31:0] rd_value;

  assign rd_value =
    hit_counter ? count_reg :
    hit_match_a ? match_a_reg :
    hit_match_b ? match_b_reg :
    hit_load ? load_reg :
    hit_control ? {wc_reg, 23'h000000, ctrl_reg} :
    hit_mask ? {28'h0000000, mask_reg} :
    hit_raw ? {28'h0000000, raw_reg} :
    hit_masked ? {28'h0000000, masked_status} :
    hit_trim ? {16'h0000, trim_reg} :
    `RST_ZERO32;

  // ==========================================================================
  // State updates
  // ==========================================================================
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      prdata_reg <= `RST_ZERO32;
      data_sel_reg <= 1'b0;
    end else if (CE && setup_phase) begin
      prdata_reg <= rd_value;
      data_sel_reg <= hit_data;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl_reg <= `RST_CONTROL;
      wc_reg <= 1'b1;
      state_reg <= hib_pkg::AWAKE;
      raw_reg <= {`EV_WIDTH{1'b0}};
      eq_a_prev_reg <= 1'b0;
      eq_b_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b1;
      wake_n_prev_reg <= 1'b1;
    end else if (CE) begin
      ctrl_reg <= ctrl_next;
      wc_reg <= wc_next;
      state_reg <= state_next;
      raw_reg <= raw_next;
      eq_a_prev_reg <= eq_a;
      eq_b_prev_reg <= eq_b;
      ref_prev_reg <= ref_level;
      wake_n_prev_reg <= wake_n_level;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      count_reg <= `RST_ZERO32;
      prediv_reg <= `PREDIV_NOMINAL;
      sec_index_reg <= 6'h00;
      xtal_div_reg <= 7'h00;
    end else if (CE) begin
      count_reg <= count_next;
      prediv_reg <= prediv_next;
      if (sec_strobe) begin
        sec_index_reg <= sec_index_reg + 6'h01;
      end
      if (ref_clock_on && ref_edge) begin
        xtal_div_reg <= xtal_div_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      match_a_reg <= `RST_MATCH;
      match_b_reg <= `RST_MATCH;
      load_reg <= `RST_LOAD;
      trim_reg <= `RST_TRIM;
      mask_reg <= {`EV_WIDTH{1'b0}};
    end else if (CE && wr_access) begin
      if (hit_match_a) begin
        match_a_reg <= PWDATA;
      end
      if (hit_match_b) begin
        match_b_reg <= PWDATA;
      end
      if (hit_load) begin
        load_reg <= PWDATA;
      end
      if (hit_trim) begin
        trim_reg <= PWDATA[15:0];
      end
      if (hit_mask) begin
        mask_reg <= PWDATA[`EV_WIDTH-1:0]; // [RULE_22]
      end
    end
  end

endmodule

// >>> rtl/hib_defs.svh
`ifndef HIB_DEFS_SVH
`define HIB_DEFS_SVH

// Register byte offsets
`define OFF_COUNTER 12'h000
`define OFF_MATCH_A 12'h004
`define OFF_MATCH_B 12'h008
`define OFF_LOAD 12'h00C
`define OFF_CONTROL 12'h010
`define OFF_MASK 12'h014
`define OFF_RAW 12'h018
`define OFF_MASKED 12'h01C
`define OFF_CLEAR 12'h020
`define OFF_TRIM 12'h024
`define OFF_DATA_FIRST 12'h030
`define OFF_DATA_LAST 12'h12C
// Word index of the first retained word
`define DATA_FIRST_WORD 10'h00C

// Control register field positions
`define CTL_COUNTER_ENABLE 0
`define CTL_SLEEP_REQUEST 1
`define CTL_REF_SOURCE_SELECT 2
`define CTL_MATCH_WAKE_ENABLE 3
`define CTL_PIN_WAKE_ENABLE 4
`define CTL_LOW_BATT_DETECT_ENABLE 5
`define CTL_REF_CLOCK_ENABLE 6
`define CTL_LOW_BATT_ABORT 7
`define CTL_WIDTH 8

// Event bit positions
`define EV_MATCH_A 0
`define EV_MATCH_B 1
`define EV_LOW_BATT 2
`define EV_WAKE_PIN 3
`define EV_WIDTH 4

// Reset values
`define RST_MATCH 32'hFFFFFFFF
`define RST_LOAD 32'hFFFFFFFF
`define RST_CONTROL 8'h00
`define RST_TRIM 16'h7FFF
`define RST_ZERO32 32'h00000000
// Idle pin levels, order {VBAT_OK, LOW_BATT_IN, WAKE_N, REF_CLK_IN}
`define RST_PIN_LEVELS 4'hA

// Predivider
`define PREDIV_NOMINAL 16'h7FFF
`define TRIM_SECOND_INDEX 6'h3F
`define XTAL_DIV_LAST 7'h7F

`endif

// >>> rtl/hib_pkg.sv
package hib_pkg;
  typedef enum logic {
    AWAKE,
    HIBERNATE
  } power_state_e;
endpackage

// >>> rtl/retained_memory.sv
`timescale 1ns/100ps
module retained_memory #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  // Contents are not reset: they live on the backup supply
  logic [WIDTH-1:0] mem_array [DEPTH];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem_array[addr] <= wr_data;
      end
      rd_data <= mem_array[addr];
    end
  end
endmodule

// >>> test/hib_asserts.sv
`timescale 1ns/100ps
`include "hib_defs.svh"
module hib_asserts (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic WAKE_N,
  input wire logic REGULATOR_OFF_N_OUT,
  input wire logic REGULATOR_OFF_N_OE,
  input wire logic IRQ
);
  // ==========================================
  // Decoded bus events
  wire acc = PSEL && PENABLE && CE;
  wire wr_sleep = acc && PWRITE && PADDR == `OFF_CONTROL && PWDATA[1];
  wire wr_mask0 = acc && PWRITE && PADDR == `OFF_MASK && PWDATA[3:0] == 4'h0;
  wire unmapped = PADDR == 12'h028 || PADDR == 12'h02C || PADDR > 12'h12C;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ==========================================
  // Properties
  ready_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase without ready");
  slverr_idle_a: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error flag outside access phase");
  slverr_map_a: assert property (PSEL && PENABLE && unmapped |-> PSLVERR)
    else $error("unmapped access not refused");
  out_low_a: assert property (!REGULATOR_OFF_N_OUT)
    else $error("regulator pin data not low");
  sleep_cause_a: assert property ($rose(REGULATOR_OFF_N_OE) |->
    $past(wr_sleep) || $past(wr_sleep, 2))
    else $error("regulator off without sleep request");
  reset_quiet_a: assert property ($fell(RESET) |->
    !IRQ && !REGULATOR_OFF_N_OE)
    else $error("outputs active after reset");
  mask_off_a: assert property (wr_mask0 |=> !IRQ)
    else $error("interrupt with all events masked");
  wake_sync_a: assert property ($fell(WAKE_N) && REGULATOR_OFF_N_OE &&
    !PSEL |=> REGULATOR_OFF_N_OE [*2])
    else $error("wake pin acted before synchronising");
  cover property ($rose(REGULATOR_OFF_N_OE));
  cover property ($fell(REGULATOR_OFF_N_OE));
  cover property ($rose(IRQ));
  cover property (PSLVERR);
endmodule

bind hibernate_rtc_power_controller hib_asserts u_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .WAKE_N(WAKE_N),
  .REGULATOR_OFF_N_OUT(REGULATOR_OFF_N_OUT),
  .REGULATOR_OFF_N_OE(REGULATOR_OFF_N_OE), .IRQ(IRQ));

// >>> test/regulator_model.sv
`timescale 1ns/100ps
module regulator_model (
  input wire logic off_out,
  input wire logic off_oe,
  input wire logic wake_hold,
  output logic wake_n,
  output logic power_good
);
  // ==========================================
  // Open-drain pin with pull-up feeding the regulator enable
  wire pin = off_oe ? off_out : 1'h1;
  assign power_good = pin;
  // Wake source pulls the pin low, weak pull-up otherwise
  assign wake_n = wake_hold ? 1'h0 : 1'h1;
endmodule

// >>> test/tb_top.sv
`timescale 1ns/100ps
`include "hib_defs.svh"
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic ref_clk = 1'h0;
  logic low_batt = 1'h0;
  logic wake_hold = 1'h0;
  wire [31:0] prdata;
  wire pready, pslverr, wake_n, reg_out, reg_oe, irq, power_good;
  logic [31:0] rdata;
  logic rerr;
  int fails = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  hibernate_rtc_power_controller uut (
    .CLK_SYS(clk), .RESET(rst), .CE(1'h1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REF_CLK_IN(ref_clk), .WAKE_N(wake_n), .LOW_BATT_IN(low_batt),
    .VBAT_OK(1'h1), .REGULATOR_OFF_N_OUT(reg_out),
    .REGULATOR_OFF_N_OE(reg_oe), .IRQ(irq));

  regulator_model partner (
    .off_out(reg_out), .off_oe(reg_oe), .wake_hold(wake_hold),
    .wake_n(wake_n), .power_good(power_good));

  // ==========================================
  // Shared tasks
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fails++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h00000000);
    chk(rdata, exp);
  endtask

  // ==========================================
  // Scenarios
  task t_reset;
    rd(`OFF_COUNTER, 32'h00000000);
    rd(`OFF_MATCH_A, 32'hFFFFFFFF);
    rd(`OFF_MATCH_B, 32'hFFFFFFFF);
    rd(`OFF_LOAD, 32'hFFFFFFFF);
    rd(`OFF_CONTROL, 32'h80000000);
    rd(`OFF_MASK, 32'h00000000);
    rd(`OFF_RAW, 32'h00000000);
    rd(`OFF_TRIM, 32'h00007FFF);
  endtask

  task t_mem;
    wr(`OFF_DATA_FIRST, 32'hA5A50001);
    wr(`OFF_DATA_LAST, 32'h5A5A003F);
    rd(`OFF_DATA_FIRST, 32'hA5A50001);
    rd(`OFF_DATA_LAST, 32'h5A5A003F);
    wr(12'h028, 32'h12345678);
    chk({31'h0, rerr}, 32'h1);
    rd(12'h028, 32'h00000000);
  endtask

  task t_match;
    wr(`OFF_MATCH_A, 32'h00000007);
    wr(`OFF_LOAD, 32'h00000007);
    rd(`OFF_COUNTER, 32'h00000007);
    rd(`OFF_RAW, 32'h00000001);
    wr(`OFF_MATCH_B, 32'h00000009);
    wr(`OFF_LOAD, 32'h00000009);
    rd(`OFF_RAW, 32'h00000003);
    chk({31'h0, irq}, 32'h0);
    wr(`OFF_MASK, 32'h00000002);
    wt(1);
    chk({31'h0, irq}, 32'h1);
    rd(`OFF_MASKED, 32'h00000002);
    rd(`OFF_RAW, 32'h00000003);
    wr(`OFF_CLEAR, 32'h00000002);
    wt(1);
    chk({31'h0, irq}, 32'h0);
    rd(`OFF_RAW, 32'h00000001);
    wr(`OFF_CLEAR, 32'h00000001);
    wr(`OFF_MASK, 32'h00000000);
  endtask

  task t_wrc;
    wr(`OFF_TRIM, 32'h00008000);
    rd(`OFF_CONTROL, 32'h00000000);
    ref_clk <= 1'h1;
    wt(10);
    rd(`OFF_CONTROL, 32'h80000000);
    ref_clk <= 1'h0;
    rd(`OFF_TRIM, 32'h00008000);
  endtask

  task t_lowbatt;
    low_batt <= 1'h1;
    wt(10);
    rd(`OFF_RAW, 32'h00000000);
    wr(`OFF_CONTROL, 32'h00000020);
    wt(10);
    rd(`OFF_RAW, 32'h00000004);
    wr(`OFF_CLEAR, 32'h00000004);
    rd(`OFF_RAW, 32'h00000004);
    wr(`OFF_CONTROL, 32'h000000B2);
    wt(4);
    chk({31'h0, reg_oe}, 32'h0);
    rd(`OFF_CONTROL, 32'h800000B0);
    low_batt <= 1'h0;
    wt(10);
    wr(`OFF_CLEAR, 32'h00000004);
    rd(`OFF_RAW, 32'h00000000);
  endtask

  task t_pin_wake;
    wr(`OFF_CONTROL, 32'h00000032);
    wt(2);
    chk({31'h0, reg_oe}, 32'h1);
    chk({31'h0, power_good}, 32'h0);
    low_batt <= 1'h1;
    wt(10);
    rd(`OFF_RAW, 32'h00000000);
    low_batt <= 1'h0;
    wt(8);
    wake_hold <= 1'h1;
    wt(10);
    wake_hold <= 1'h0;
    chk({31'h0, reg_oe}, 32'h0);
    chk({31'h0, power_good}, 32'h1);
    rd(`OFF_RAW, 32'h00000008);
    rd(`OFF_DATA_LAST, 32'h5A5A003F);
    rd(`OFF_CONTROL, 32'h80000030);
    wr(`OFF_MASK, 32'h00000008);
    wt(1);
    chk({31'h0, irq}, 32'h1);
    wr(`OFF_MASK, 32'h00000000);
    wr(`OFF_CLEAR, 32'h00000008);
  endtask

  task t_match_wake;
    wr(`OFF_CONTROL, 32'h0000000A);
    wt(2);
    wake_hold <= 1'h1;
    wt(10);
    wake_hold <= 1'h0;
    chk({31'h0, reg_oe}, 32'h1);
    rd(`OFF_RAW, 32'h00000008);
    wr(`OFF_MATCH_A, 32'h00000020);
    wr(`OFF_LOAD, 32'h00000020);
    wt(2);
    chk({31'h0, reg_oe}, 32'h0);
    rd(`OFF_RAW, 32'h00000009);
    wr(`OFF_CLEAR, 32'h0000000F);
  endtask

  task wrap_up;
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Sequence and watchdog
  initial begin
    wt(16);
    rst <= 1'h0;
    t_reset();
    t_mem();
    t_match();
    t_wrc();
    t_lowbatt();
    t_pin_wake();
    t_match_wake();
    wrap_up();
  end

  initial begin
    #80000;
    fails++;
    wrap_up();
  end
endmodule
